// [stepper_cfg_pkg.sv]
// types shared by the strap configuration loader
package stepper_cfg_pkg;
  typedef enum logic [1:0] {LVL_GND, LVL_OPEN, LVL_VIO} level_t;
  typedef enum logic [1:0] {S_PULL_LO, S_PULL_HI, S_APPLY} scan_state_t;
endpackage : stepper_cfg_pkg

// [stepper_cfg_regs.svh]
// offsets, field positions, reset values and timing counts of the strap configuration loader
// Overview of operation
// R01 - serial select low turns the serial path off and loads settings from straps.
// R02 - every strap pin decodes to ground, open or supply level.
// R03 - standalone mode: first diagnostic open drain, pulls low on driver error.
// R04 - standalone mode: second diagnostic open drain, pulls low at table home.
// R05 - off-time strap: low code 4, high code 7, open code 10.
// R06 - microstep strap pair picks resolution, interpolation and chopper per table.
// R07 - microstep straps may change chopper method while running.
// R08 - current-mode strap: internal ref, internal sense, or analog scaling.
// R09 - hysteresis strap: low code 7, high code 11, open code 15.
// R10 - blank strap: low 00, high 01, open 10.
// R11 - enable strap low: enabled, currents 31, no reduction; high: disabled.
// R12 - enable open: hold 11, delay 8, ramp down after 1M idle clocks.
// R13 - standalone voltage chopper keeps its power-on configuration word.
// R14 - off-time and hysteresis straps never touch the voltage chopper word.
// R15 - host first writes chopper word: off 3, start 4, end 1, blank 2.
// R16 - host then writes current word: hold 10, run 31, delay 6.
// R17 - host then writes standstill power-down delay 10.
// R18 - host then sets voltage chopper enable in global configuration.
// R19 - host then writes switchover velocity threshold 500.
// R20 - host finally writes voltage chopper word: auto, 2/1024, limit 200, gradient 1.
// R21 - host write is 40 bits, msb first: write flag, 7-bit address, 32 data.
// R22 - straps are decoded and applied before any step pulse is accepted; serial mode accepts steps without waiting for them.
`ifndef STEPPER_CFG_REGS_SVH
`define STEPPER_CFG_REGS_SVH
// avalon byte offsets
`define OFS_DGRAM_HDR 8'h00
`define OFS_DGRAM_DATA 8'h04
`define OFS_STATUS 8'h08
`define OFS_CHOP 8'h0C
`define OFS_CURR 8'h10
`define OFS_GLOBAL_CONFIG 8'h14
`define OFS_PWM 8'h18
`define OFS_PDN 8'h1C
`define OFS_TPWM 8'h20
// serial register addresses carried in a datagram
`define SA_GLOBAL_CONFIG 7'h00
`define SA_CURR 7'h10
`define SA_PDN 7'h11
`define SA_TPWM 7'h13
`define SA_CHOP 7'h6C
`define SA_PWM 7'h70
// field positions
`define CH_OFF_TIME_CODE 3:0
`define CH_HYSTERESIS_START_CODE 6:4
`define CH_HYSTERESIS_END_CODE 10:7
`define CH_CHM 14
`define CH_TBL 16:15
`define CH_MICROSTEP_RESOLUTION_CODE 27:24
`define CH_INTPOL 28
`define GC_ISCALE 0
`define GC_RSENSE 1
`define GC_PWMEN 2
`define GC_FIRST_DIAGNOSTIC_OUTPUT 5
`define GC_SECOND_DIAGNOSTIC_OUTPUT 6
`define CU_HOLD 4:0
`define CU_RUN 12:8
`define CU_DELAY 19:16
// reset values
`define PWM_DEFAULT 32'h0005_0480
`define CHOP_DEFAULT 32'h0000_0000
`define CURR_DEFAULT 32'h0000_0000
// timing
`define SETTLE_CLKS 16'h0010
`endif

// [stepper_standalone_pin_config.sv]
// strap sampling, serial write path and standstill current control of a stepper driver
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_cfg_regs.svh"
module stepper_standalone_pin_config
  import stepper_cfg_pkg::*;
#(
  parameter int STANDSTILL_CLKS = 1048576,
  parameter int RAMP_CLKS = 44000000
)(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_serial_mode,
  input wire logic [6:0] i_strap,
  output logic o_strap_pull_up,
  input wire logic i_step,
  input wire logic i_driver_error,
  input wire logic i_table_home,
  output logic o_diag_level,
  output logic o_diag_a_oe,
  output logic o_diag_b_oe,
  output logic [31:0] o_chopper_config_word,
  output logic [31:0] o_global_config,
  output logic [31:0] o_voltage_pwm_config_word,
  output logic o_driver_enable,
  output logic [4:0] o_current_scale,
  output logic o_step_accept
);
  localparam int RAMP_STEPS = 20;
  localparam int RAMP_STEP_CLKS = RAMP_CLKS / RAMP_STEPS;

  // strap decode from a pulled-low and a pulled-high sample
  function automatic level_t strap_level(input logic lo, input logic hi);
    if (lo)
      return LVL_VIO;
    else if (!hi)
      return LVL_GND;
    else
      return LVL_OPEN;
  endfunction : strap_level

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  always_ff @(posedge i_mclk)
  begin
    meta_q <= {i_step, i_serial_mode, i_strap};
    sync_q <= meta_q;
  end
  wire logic [6:0] strap_s = sync_q[6:0];
  wire logic serial_s = sync_q[7];
  wire logic step_s = sync_q[8];
  logic step_prev_q;
  always_ff @(posedge i_mclk)
    step_prev_q <= step_s;
  wire logic step_rise = step_s & ~step_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // strap scan: pull low, sample, pull high, sample, decode; runs forever
  scan_state_t state_q;
  logic [15:0] settle_q;
  logic [6:0] lo_q;
  logic cfg_valid_q;
  // R02 three-state detect
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      state_q <= S_PULL_LO;
      settle_q <= 16'h0000;
      lo_q <= 7'h00;
      o_strap_pull_up <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_PULL_LO:
          if (settle_q == `SETTLE_CLKS)
          begin
            lo_q <= strap_s;
            o_strap_pull_up <= 1'b1;
            settle_q <= 16'h0000;
            state_q <= S_PULL_HI;
          end
          else
            settle_q <= settle_q + 16'h0001;
        S_PULL_HI:
          if (settle_q == `SETTLE_CLKS)
          begin
            o_strap_pull_up <= 1'b0;
            settle_q <= 16'h0000;
            state_q <= S_APPLY;
          end
          else
            settle_q <= settle_q + 16'h0001;
        default:
          state_q <= S_PULL_LO;
      endcase
    end
  end
  wire logic scan_apply = (state_q == S_PULL_HI) && (settle_q == `SETTLE_CLKS);

  // decoded levels of each strap
  level_t lv [7];
  always_comb
    for (int i = 0; i < 7; i++)
      lv[i] = strap_level(lo_q[i], strap_s[i]);

  ////////////////////////////////////////////////////////////////////////////
  // standalone settings from straps
  logic [31:0] st_chop_q;
  logic [31:0] st_global_config_q;
  logic [1:0] st_enable_q;
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      st_chop_q <= `CHOP_DEFAULT;
      st_global_config_q <= 32'h0000_0000;
      st_enable_q <= 2'b00;
      cfg_valid_q <= 1'b0;
    end
    else if (scan_apply)
    begin
      cfg_valid_q <= 1'b1;
      st_chop_q <= 32'h0000_0000;
      // R05 off time
      st_chop_q[`CH_OFF_TIME_CODE] <= (lv[0] == LVL_GND) ? 4'd4 : (lv[0] == LVL_VIO) ? 4'd7 : 4'd10;
      // R09 hysteresis end
      st_chop_q[`CH_HYSTERESIS_END_CODE] <= (lv[4] == LVL_GND) ? 4'd7 : (lv[4] == LVL_VIO) ? 4'd11 : 4'd15;
      // R10 blank time
      st_chop_q[`CH_TBL] <= (lv[5] == LVL_GND) ? 2'b00 : (lv[5] == LVL_VIO) ? 2'b01 : 2'b10;
      // R06 microstep pair, high strap first
      case ({lv[2], lv[1]})
        {LVL_GND, LVL_GND}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd8;
        {LVL_GND, LVL_VIO}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd7;
        {LVL_VIO, LVL_GND}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd6;
        {LVL_VIO, LVL_VIO}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd4;
        {LVL_GND, LVL_OPEN}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd7;
        {LVL_VIO, LVL_OPEN}, {LVL_OPEN, LVL_VIO}: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd6;
        default: st_chop_q[`CH_MICROSTEP_RESOLUTION_CODE] <= 4'd4;
      endcase
      st_chop_q[`CH_INTPOL] <= (lv[1] == LVL_OPEN) || (lv[2] == LVL_OPEN);
      // R03 R04 diagnostics in open drain mode
      st_global_config_q[`GC_FIRST_DIAGNOSTIC_OUTPUT] <= 1'b1;
      st_global_config_q[`GC_SECOND_DIAGNOSTIC_OUTPUT] <= 1'b1;
      // R07 chopper method follows the microstep straps on every scan
      st_global_config_q[`GC_PWMEN] <= (lv[2] == LVL_OPEN) && (lv[1] != LVL_GND);
      // R08 current reference
      st_global_config_q[`GC_RSENSE] <= (lv[3] == LVL_VIO);
      st_global_config_q[`GC_ISCALE] <= (lv[3] == LVL_OPEN);
      st_enable_q <= lv[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the request completes
  logic [7:0] hdr_q;
  logic [31:0] chop_q, curr_q, global_config_q, pwm_q, pdn_q, tpwm_q;
  wire logic req = i_avs_read | i_avs_write;
  wire logic done = req & ~o_avs_waitrequest;
  wire logic wr_done = i_avs_write & ~o_avs_waitrequest;
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
  end

  // R21 header byte then data word form one 40-bit datagram
  wire logic dg_go = wr_done && (i_avs_address == `OFS_DGRAM_DATA) && hdr_q[7] && serial_s;
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      hdr_q <= 8'h00;
    else if (wr_done && (i_avs_address == `OFS_DGRAM_HDR) && i_avs_byteenable[0])
      hdr_q <= i_avs_writedata[7:0];
  end

  // serial register file; R01 writes only land when serial mode is selected
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      chop_q <= `CHOP_DEFAULT;
      curr_q <= `CURR_DEFAULT;
      global_config_q <= 32'h0000_0000;
      pwm_q <= `PWM_DEFAULT;
      pdn_q <= 32'h0000_0000;
      tpwm_q <= 32'h0000_0000;
    end
    else if (dg_go)
    begin
      case (hdr_q[6:0])
        `SA_CHOP: chop_q <= merge(chop_q, i_avs_writedata, i_avs_byteenable);
        `SA_CURR: curr_q <= merge(curr_q, i_avs_writedata, i_avs_byteenable);
        `SA_PDN: pdn_q <= merge(pdn_q, i_avs_writedata, i_avs_byteenable);
        `SA_GLOBAL_CONFIG: global_config_q <= merge(global_config_q, i_avs_writedata, i_avs_byteenable);
        `SA_TPWM: tpwm_q <= merge(tpwm_q, i_avs_writedata, i_avs_byteenable);
        `SA_PWM: pwm_q <= merge(pwm_q, i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // read data set in the wait cycle, stands at the completing edge
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && o_avs_waitrequest)
    begin
      case (i_avs_address)
        `OFS_DGRAM_HDR: o_avs_readdata <= {24'h00_0000, hdr_q};
        `OFS_STATUS: o_avs_readdata <= {24'h00_0000, o_step_accept, serial_s, lv[6], lv[1],
                                        lv[2]};
        `OFS_CHOP: o_avs_readdata <= o_chopper_config_word;
        `OFS_CURR: o_avs_readdata <= curr_q;
        `OFS_GLOBAL_CONFIG: o_avs_readdata <= o_global_config;
        `OFS_PWM: o_avs_readdata <= o_voltage_pwm_config_word;
        `OFS_PDN: o_avs_readdata <= pdn_q;
        `OFS_TPWM: o_avs_readdata <= tpwm_q;
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective configuration; R01 selects the source
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_chopper_config_word <= `CHOP_DEFAULT;
      o_global_config <= 32'h0000_0000;
      o_voltage_pwm_config_word <= `PWM_DEFAULT;
      o_step_accept <= 1'b0;
    end
    else
    begin
      o_chopper_config_word <= serial_s ? chop_q : st_chop_q;
      o_global_config <= serial_s ? global_config_q : st_global_config_q;
      // R13 R14 standalone keeps the power-on voltage chopper word
      o_voltage_pwm_config_word <= serial_s ? pwm_q : `PWM_DEFAULT;
      // R22 standalone steps accepted only once straps have been applied; serial mode accepts steps at once
      o_step_accept <= serial_s | cfg_valid_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and standstill current; R11 R12
  wire logic [4:0] run_s = serial_s ? curr_q[`CU_RUN] : 5'd31;
  wire logic [4:0] hold_s = serial_s ? curr_q[`CU_HOLD] :
                            (st_enable_q == LVL_OPEN) ? 5'd11 : 5'd31;
  logic [31:0] idle_q;
  logic [31:0] ramp_q;
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_driver_enable <= 1'b0;
      o_current_scale <= 5'd0;
      idle_q <= 32'h0000_0000;
      ramp_q <= 32'h0000_0000;
    end
    else
    begin
      // R11 high strap disables the driver
      o_driver_enable <= serial_s ? (chop_q[`CH_OFF_TIME_CODE] != 4'd0) :
                         (cfg_valid_q && st_enable_q != LVL_VIO);
      if (step_rise && o_step_accept)
      begin
        idle_q <= 32'h0000_0000;
        ramp_q <= 32'h0000_0000;
        o_current_scale <= run_s;
      end
      else if (idle_q < STANDSTILL_CLKS)
      begin
        idle_q <= idle_q + 32'h0000_0001;
        o_current_scale <= run_s;
      end
      // R12 one scale step down per ramp interval until hold is reached
      else if (o_current_scale > hold_s)
      begin
        if (ramp_q == RAMP_STEP_CLKS - 1)
        begin
          ramp_q <= 32'h0000_0000;
          o_current_scale <= o_current_scale - 5'd1;
        end
        else
          ramp_q <= ramp_q + 32'h0000_0001;
      end
      else
        o_current_scale <= hold_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain diagnostics; data is always low, enable pulls the line
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_diag_level <= 1'b0;
      o_diag_a_oe <= 1'b0;
      o_diag_b_oe <= 1'b0;
    end
    else
    begin
      o_diag_level <= 1'b0;
      // R03 fault pulls first output
      o_diag_a_oe <= o_global_config[`GC_FIRST_DIAGNOSTIC_OUTPUT] & i_driver_error;
      // R04 table home pulls second output
      o_diag_b_oe <= o_global_config[`GC_SECOND_DIAGNOSTIC_OUTPUT] & i_table_home;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_no_early_step: assert property (@(posedge i_mclk) disable iff (i_reset) // R22
    (!serial_s && !cfg_valid_q) |=> !o_step_accept) else $error("step accepted early");
  a_standalone_pwm: assert property (@(posedge i_mclk) disable iff (i_reset) // R13
    !serial_s |=> o_voltage_pwm_config_word == `PWM_DEFAULT)
    else $error("pwm word not default");
  a_off_time_code_open: assert property (@(posedge i_mclk) disable iff (i_reset) // R05
    scan_apply && lv[0] == LVL_OPEN |=> st_chop_q[`CH_OFF_TIME_CODE] == 4'd10)
    else $error("off time code wrong");
  a_hysteresis_end_code_gnd: assert property (@(posedge i_mclk) disable iff (i_reset) // R09
    scan_apply && lv[4] == LVL_GND |=> st_chop_q[`CH_HYSTERESIS_END_CODE] == 4'd7)
    else $error("hysteresis code wrong");
  a_blank_vio: assert property (@(posedge i_mclk) disable iff (i_reset) // R10
    scan_apply && lv[5] == LVL_VIO |=> st_chop_q[`CH_TBL] == 2'b01)
    else $error("blank code wrong");
  a_vchop_sel: assert property (@(posedge i_mclk) disable iff (i_reset) // R06
    scan_apply && lv[2] == LVL_GND |=> !st_global_config_q[`GC_PWMEN])
    else $error("voltage chopper wrongly selected");
  a_serial_off: assert property (@(posedge i_mclk) disable iff (i_reset) // R01
    wr_done && !serial_s |=> $stable(chop_q) && $stable(curr_q))
    else $error("write landed in standalone mode");
  a_diag_fault: assert property (@(posedge i_mclk) disable iff (i_reset) // R03
    !serial_s && !$past(serial_s) && cfg_valid_q && $past(cfg_valid_q) && i_driver_error
    |=> o_diag_a_oe)
    else $error("fault not signalled");
  a_disable_vio: assert property (@(posedge i_mclk) disable iff (i_reset) // R11
    !serial_s && st_enable_q == LVL_VIO |=> !o_driver_enable)
    else $error("driver enabled by high strap");
  a_wait_one: assert property (@(posedge i_mclk) disable iff (i_reset) // one avalon wait cycle per request
    req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("wait cycle wrong");
endmodule : stepper_standalone_pin_config
`default_nettype wire

// [stepper_standalone_pin_config_test.sv]
// self-checking bench of the strap configuration loader and its host write path
`timescale 1ns/1ps
`default_nettype none
`include "stepper_cfg_regs.svh"
module stepper_standalone_pin_config_test
  import stepper_cfg_pkg::*;
;
  localparam int IDLE_CLKS = 50;
  localparam int RAMP = 200;
  logic mclk = 0, reset = 1, read = 0, write = 0, serial_mode = 0, step = 0;
  logic driver_error = 0, table_home = 0, waitrequest, pull_up, diag_level, diag_a_oe, diag_b_oe;
  logic driver_enable, step_accept;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, chop, global_config, pwm, rd;
  logic [4:0] cur;
  logic [6:0] strap;
  logic [13:0] levels = 14'h0000;
  int err_count = 0, compares = 0, cycles = 0;
  level_t lv [3] = '{LVL_GND, LVL_VIO, LVL_OPEN};
  logic [3:0] microstep_resolution_code [9] = '{4'h8, 4'h7, 4'h7, 4'h6, 4'h4, 4'h6, 4'h4, 4'h6, 4'h4};
  logic ipol [9] = '{0, 0, 1, 0, 0, 1, 1, 1, 1};
  logic [39:0] dg [6] = '{40'hEC_0001_00C3, 40'h90_0006_1F0A, 40'h91_0000_000A,
    40'h80_0000_0004, 40'h93_0000_01F4, 40'hF0_0004_01C8};
  logic [7:0] ofs [6] = '{`OFS_CHOP, `OFS_CURR, `OFS_PDN, `OFS_GLOBAL_CONFIG, `OFS_TPWM, `OFS_PWM};
  logic [31:0] e;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and board
  always #50 mclk = ~mclk;
  stepper_standalone_pin_config #(.STANDSTILL_CLKS(IDLE_CLKS), .RAMP_CLKS(RAMP))
  stepper_standalone_pin_config_i (.i_mclk(mclk), .i_reset(reset), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
    .i_serial_mode(serial_mode), .i_strap(strap), .o_strap_pull_up(pull_up), .i_step(step),
    .i_driver_error(driver_error), .i_table_home(table_home), .o_diag_level(diag_level),
    .o_diag_a_oe(diag_a_oe), .o_diag_b_oe(diag_b_oe), .o_chopper_config_word(chop),
    .o_global_config(global_config), .o_voltage_pwm_config_word(pwm),
    .o_driver_enable(driver_enable), .o_current_scale(cur), .o_step_accept(step_accept));
  strap_board_model strap_board_model_i (.i_strap_pull_up(pull_up), .i_levels(levels),
    .o_strap(strap));
  ////////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and hang guard
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // a hung handshake would otherwise stall forever
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: request held until waitrequest is seen low at a rising edge
  task bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_write
  task bus_read(input logic [7:0] a);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
  endtask : bus_read
  // one host datagram: header byte first, then the 32 data bits
  task send(input logic [39:0] d);
    bus_write(`OFS_DGRAM_HDR, {24'h00_0000, d[39:32]});
    bus_write(`OFS_DGRAM_DATA, d[31:0]);
  endtask : send
  task wait_clks(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_clks
  task pulse_step;
    @(posedge mclk);
    step <= 1'b1;
    wait_clks(4);
    step <= 1'b0;
  endtask : pulse_step
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    // outputs hold their reset values from the first edge on
    wait_clks(2);
    check(waitrequest, 1'b1);
    check(pwm, `PWM_DEFAULT);
    reset <= 1'b0;
    @(posedge mclk);
    check(chop, 32'h0000_0000);
    check(global_config, 32'h0000_0000);
    check({driver_enable, step_accept}, 2'b00);
    // every microstep pair in turn, other straps cycling through all three states
    for (int k = 0; k < 9; k++)
    begin
      levels <= {7{lv[k % 3]}};
      levels[5:2] <= {lv[k / 3], lv[k % 3]};
      wait_clks(120);
      e = {3'b000, ipol[k], microstep_resolution_code[k], 24'h00_0000} | (32'(k % 3) << 15);
      e = e | (32'(k % 3 == 0 ? 7 : k % 3 == 1 ? 11 : 15) << 7);
      e = e | 32'(k % 3 == 0 ? 4 : k % 3 == 1 ? 7 : 10);
      check(chop, e);
      check(global_config, 32'h60 | (k >= 7 ? 32'h4 : 32'h0) | 32'(k % 3 == 1 ? 2 : k % 3 == 2 ? 1 : 0));
      check(pwm, `PWM_DEFAULT);
      check(driver_enable, k % 3 != 1);
      check(step_accept, 1'b1);
    end
    levels <= 14'h0000;
    wait_clks(120);
    check(chop, 32'h0800_0384);
    check(cur, 5'd31);
    driver_error <= 1'b1;
    wait_clks(4);
    check({diag_a_oe, diag_b_oe, diag_level}, 3'b100);
    driver_error <= 1'b0;
    table_home <= 1'b1;
    wait_clks(4);
    check({diag_a_oe, diag_b_oe, diag_level}, 3'b010);
    table_home <= 1'b0;
    // standstill reduction only with the enable strap open
    pulse_step();
    wait_clks(IDLE_CLKS + RAMP + 60);
    check(cur, 5'd31);
    levels[13:12] <= LVL_OPEN;
    wait_clks(60);
    pulse_step();
    wait_clks(20);
    check(cur, 5'd31);
    wait_clks(IDLE_CLKS + RAMP + 60);
    check(cur, 5'd11);
    pulse_step();
    wait_clks(8);
    check(cur, 5'd31);
    // host writes are ignored while standalone
    send(dg[0]);
    wait_clks(4);
    check(chop, 32'h0800_0384);
    serial_mode <= 1'b1;
    wait_clks(20);
    // the refused standalone write must not have reached the serial chopper word
    check(chop, 32'h0000_0000);
    check(driver_enable, 1'b0);
    // host setup order: chopper, currents, power-down, pwm enable, threshold, pwm word
    for (int i = 0; i < 6; i++)
      send(dg[i]);
    for (int i = 0; i < 6; i++)
    begin
      bus_read(ofs[i]);
      check(rd, dg[i][31:0]);
    end
    check(chop, 32'h0001_00C3);
    check(global_config, 32'h0000_0004);
    check(pwm, 32'h0004_01C8);
    bus_read(`OFS_CURR);
    check(rd, 32'h0006_1F0A);
    bus_read(`OFS_PDN);
    check(rd, 32'h0000_000A);
    bus_read(`OFS_TPWM);
    check(rd, 32'h0000_01F4);
    check(driver_enable, 1'b1);
    // header without write flag, then an unknown address: both leave state alone
    send({8'h6C, 32'h1234_5678});
    send({8'hFF, 32'h1234_5678});
    bus_read(`OFS_CHOP);
    check(rd, 32'h0001_00C3);
    bus_read(8'h40);
    check(rd, 32'h0000_0000);
    results();
  end
endmodule : stepper_standalone_pin_config_test
`default_nettype wire

// [strap_board_model.sv]
// board strapping model: tied pins stay fixed, open pins follow the loader's weak pull
`timescale 1ns/1ps
`default_nettype none
module strap_board_model
  import stepper_cfg_pkg::*;
(
  input wire logic i_strap_pull_up,
  input wire logic [13:0] i_levels,
  output logic [6:0] o_strap
);
  ////////////////////////////////////////////////////////////////////////////////
  // an open pin has no driver of its own, so only the weak pull decides its level
  always_comb
  begin
    for (int k = 0; k < 7; k++)
    begin
      case (level_t'(i_levels[2*k +: 2]))
        LVL_GND: o_strap[k] = 1'b0;
        LVL_VIO: o_strap[k] = 1'b1;
        default: o_strap[k] = i_strap_pull_up;
      endcase
    end
  end
endmodule : strap_board_model
`default_nettype wire
